// *** hw/dcfs_defines.svh ***
// constants for the dual-clock fifo with status flags
`ifndef DCFS_DEFINES_SVH
`define DCFS_DEFINES_SVH

// register byte offsets on the ahb-lite slave
`define DCFS_REG_STATUS      8'h00
`define DCFS_REG_EMPTY_OFS   8'h04
`define DCFS_REG_FULL_OFS    8'h08
`define DCFS_REG_WORD_COUNT  8'h0C

// status register bit positions
`define DCFS_ST_FALLTHROUGH  0
`define DCFS_ST_SERIAL_LOAD  1
`define DCFS_ST_EMPTY_N      2
`define DCFS_ST_FULL_N       3
`define DCFS_ST_OUT_READY_N  4
`define DCFS_ST_INPUT_SPACE_N 5
`define DCFS_ST_ALMOST_EMPTY_N 6
`define DCFS_ST_HALF_FULL_N  7
`define DCFS_ST_ALMOST_FULL_N 8

// default offsets, indexed by {offset_load_n, offset_select1, offset_select0}
`define DCFS_OFS_SEL_000     17'h0007F
`define DCFS_OFS_SEL_001     17'h01FFF
`define DCFS_OFS_SEL_010     17'h03FFF
`define DCFS_OFS_SEL_011     17'h00FFF
`define DCFS_OFS_SEL_100     17'h003FF
`define DCFS_OFS_SEL_101     17'h001FF
`define DCFS_OFS_SEL_110     17'h007FF
`define DCFS_OFS_SEL_111     17'h000FF

// synchroniser depths of the flag outputs, in link clock edges
`define DCFS_SYNC_STD_STAGES 2
`define DCFS_SYNC_FALL_STAGES 3

// pin bundle positions of the sampled control pins
`define DCFS_PIN_WCLK        0
`define DCFS_PIN_RCLK        1
`define DCFS_PIN_WEN_N       2
`define DCFS_PIN_REN_N       3
`define DCFS_PIN_MRST_N      4
`define DCFS_PIN_MODE        5
`define DCFS_PIN_LOAD_N      6
`define DCFS_PIN_SEL0        7
`define DCFS_PIN_SEL1        8
`define DCFS_PIN_COUNT       9

`endif

// *** hw/dcfs_pkg.sv ***
// types of the dual-clock fifo with status flags
`default_nettype none
package dcfs_pkg;

  typedef enum logic
  {
    DCFS_STANDARD,
    DCFS_FALLTHROUGH
  } dcfs_mode_type;

  typedef enum logic [1:0]
  {
    DCFS_BUS_IDLE,
    DCFS_BUS_WAIT,
    DCFS_BUS_RESP
  } dcfs_bus_state_type;

endpackage

`default_nettype wire

// *** hw/dcfs_fifo.sv ***
// dual-clock fifo with standard and fall-through status flags, ahb-lite registers
// Function
// RQ1: mode pin latched at master reset selects timing
// RQ2: fall-through first word appears after three edges
// RQ3: standard reader requests every word with enable
// RQ4: write enable low captures data each edge
// RQ5: standard empty flag rises after first write
// RQ6: standard almost-empty rises above n words
// RQ7: standard half-full falls past half depth
// RQ8: standard almost-full falls at depth minus m
// RQ9: standard full flag at depth blocks writes
// RQ10: standard reads release full, almost-full, half-full
// RQ11: standard almost-empty falls at n words
// RQ12: standard empty falls, reads ignored when empty
// RQ13: flags pass two or three synchroniser stages; the almost-empty, half-full and almost-full flags pass none
// RQ14: fall-through ready flag falls after first write
// RQ15: fall-through almost-empty rises above n+1 words
// RQ16: fall-through half-full falls one word later
// RQ17: fall-through almost-full falls at depth+1-m
// RQ18: fall-through input space closes at depth+1
// RQ19: fall-through reads reopen space, release flags
// RQ20: fall-through almost-empty falls at n+1 words
// RQ21: fall-through ready rises when empty, reads ignored
// RQ22: load and select pins choose default offsets
// RQ23: master reset clears pointers, flags show empty
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dcfs_defines.svh"

module dcfs_fifo #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 16
) (
  // clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic                ce_i,
  // fifo pins, asynchronous to clk_i
  input  wire logic                wclk_i,
  input  wire logic                rclk_i,
  input  wire logic                write_enable_n_i,
  input  wire logic                read_enable_n_i,
  input  wire logic                master_reset_n_i,
  input  wire logic                fallthrough_select_serial_in_i,
  input  wire logic                offset_load_n_i,
  input  wire logic                offset_select0_i,
  input  wire logic                offset_select1_i,
  input  wire logic [DATA_W-1:0]   data_in_i,
  // fifo outputs
  output logic [DATA_W-1:0]        data_out_o,
  output logic                     empty_flag_n_o,
  output logic                     full_flag_n_o,
  output logic                     output_ready_n_o,
  output logic                     input_space_n_o,
  output logic                     almost_empty_n_o,
  output logic                     half_full_n_o,
  output logic                     almost_full_n_o,
  // ahb-lite slave
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic [31:0]              hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o
);

  localparam int CW    = ADDR_W + 2;
  // offsets keep the full width of the default table even for a shallow memory
  localparam int OFS_W = (ADDR_W >= 17) ? ADDR_W + 1 : 17;
  localparam int TW    = ((CW > OFS_W) ? CW : OFS_W) + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'({1'b1, {ADDR_W{1'b0}}});
  localparam logic [CW-1:0] HALF_C  = CW'({1'b1, {(ADDR_W-1){1'b0}}});

  // pin synchronisers; stage 3 gives the value just before a clock edge
  logic [`DCFS_PIN_COUNT-1:0] pin_s1_q;
  logic [`DCFS_PIN_COUNT-1:0] pin_s2_q;
  logic [`DCFS_PIN_COUNT-1:0] pin_s3_q;
  logic [DATA_W-1:0]          din_s1_q;
  logic [DATA_W-1:0]          din_s2_q;
  logic [DATA_W-1:0]          din_s3_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end
    else if (ce_i)
    begin
      pin_s1_q <= {offset_select1_i, offset_select0_i, offset_load_n_i,
                   fallthrough_select_serial_in_i, master_reset_n_i,
                   read_enable_n_i, write_enable_n_i, rclk_i, wclk_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // data lanes need no reset, they are qualified by the sampled enables
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      din_s1_q <= data_in_i;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  wire logic wclk_rise = pin_s2_q[`DCFS_PIN_WCLK] & ~pin_s3_q[`DCFS_PIN_WCLK];
  wire logic rclk_rise = pin_s2_q[`DCFS_PIN_RCLK] & ~pin_s3_q[`DCFS_PIN_RCLK];
  wire logic wen_low   = ~pin_s3_q[`DCFS_PIN_WEN_N];
  wire logic ren_low   = ~pin_s3_q[`DCFS_PIN_REN_N];
  wire logic mrst      = ~pin_s2_q[`DCFS_PIN_MRST_N];
  wire logic [2:0] ofs_sel = {pin_s2_q[`DCFS_PIN_LOAD_N], pin_s2_q[`DCFS_PIN_SEL1],
                              pin_s2_q[`DCFS_PIN_SEL0]};

  // state
  dcfs_pkg::dcfs_mode_type mode_q;
  logic                    serial_load_q;
  logic [OFS_W-1:0]        empty_ofs_q;
  logic [OFS_W-1:0]        full_ofs_q;
  logic [ADDR_W-1:0]       wr_ptr_q;
  logic [ADDR_W-1:0]       rd_ptr_q;
  logic [ADDR_W:0]         count_q;
  logic                    out_valid_q;
  logic [1:0]              empty_sync_q;
  logic [1:0]              full_sync_q;
  logic [1:0]              space_sync_q;
  logic [1:0]              fall_pipe_q;
  logic                    almost_empty_n_q;
  logic                    half_full_n_q;
  logic                    almost_full_n_q;
  logic [DATA_W-1:0]       data_out_q;
  logic [DATA_W-1:0]       mem_q [2**ADDR_W];

  // ahb-lite slave state, declared ahead of the offset registers that it writes
  dcfs_pkg::dcfs_bus_state_type bus_q;
  logic [7:0]                   reg_addr_q;
  logic                         reg_write_q;
  logic                         reg_hit_q;
  logic [31:0]                  hrdata_q;

  wire logic bus_take = hreadyout_o & hready_i & hsel_i & htrans_i[1];
  wire logic reg_wr   = (bus_q == dcfs_pkg::DCFS_BUS_WAIT) & reg_write_q & reg_hit_q;

  // default offset decode
  logic [16:0] default_ofs;
  always_comb
  begin
    case (ofs_sel) // [RQ22]
      3'h0:    default_ofs = `DCFS_OFS_SEL_000;
      3'h1:    default_ofs = `DCFS_OFS_SEL_001;
      3'h2:    default_ofs = `DCFS_OFS_SEL_010;
      3'h3:    default_ofs = `DCFS_OFS_SEL_011;
      3'h4:    default_ofs = `DCFS_OFS_SEL_100;
      3'h5:    default_ofs = `DCFS_OFS_SEL_101;
      3'h6:    default_ofs = `DCFS_OFS_SEL_110;
      default: default_ofs = `DCFS_OFS_SEL_111;
    endcase
  end

  // occupancy and thresholds; fall-through counts the output register too
  wire logic            fall     = (mode_q == dcfs_pkg::DCFS_FALLTHROUGH);
  wire logic [CW-1:0]   adj      = CW'(fall);
  wire logic [CW-1:0]   words    = CW'(count_q) + CW'(out_valid_q);
  wire logic            mem_any  = (count_q != '0);
  wire logic            full_raw = (words == DEPTH_C + adj); // [RQ9] [RQ18]
  // offset compares run wide and add instead of subtract, so no threshold wraps
  wire logic [TW-1:0]   words_w  = TW'(words);
  wire logic [TW-1:0]   adj_w    = TW'(fall);
  wire logic [TW-1:0]   full_lvl = TW'(DEPTH_C) + adj_w;
  wire logic            ae_n_d   = (words_w > TW'(empty_ofs_q) + adj_w); // [RQ6][RQ11][RQ15][RQ20]
  wire logic            hf_n_d   = ~(words > HALF_C + adj); // [RQ7] [RQ16]
  wire logic            af_n_d   = ~(words_w + TW'(full_ofs_q) >= full_lvl); // [RQ8] [RQ17]

  // accepted transfers; the internal fill level guards against stale flags
  wire logic wr_room  = fall ? ~space_sync_q[1] : full_sync_q[1];
  wire logic wr_go    = wclk_rise & wen_low & wr_room & ~full_raw & ~mrst; // [RQ4] [RQ9] [RQ18]
  wire logic std_rd   = ~fall & rclk_rise & ren_low & empty_sync_q[1] & mem_any; // [RQ3] [RQ12]
  wire logic fall_rd  = fall & rclk_rise & ren_low & out_valid_q; // [RQ21]
  // two pipe stages plus out_valid_q give the three read edges of the first word
  wire logic fall_1st = fall & rclk_rise & ~out_valid_q & fall_pipe_q[1] & mem_any; // [RQ2]
  wire logic mem_pop  = (std_rd | fall_1st | (fall_rd & mem_any)) & ~mrst;

  // configuration is caught while master reset is held
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_q        <= dcfs_pkg::DCFS_STANDARD;
      serial_load_q <= 1'b0;
      empty_ofs_q   <= OFS_W'(`DCFS_OFS_SEL_000);
      full_ofs_q    <= OFS_W'(`DCFS_OFS_SEL_000);
    end
    else if (ce_i)
    begin
      if (mrst)
      begin
        mode_q        <= pin_s2_q[`DCFS_PIN_MODE] ? dcfs_pkg::DCFS_FALLTHROUGH
                                                 : dcfs_pkg::DCFS_STANDARD; // [RQ1]
        serial_load_q <= pin_s2_q[`DCFS_PIN_LOAD_N]; // [RQ22]
        empty_ofs_q   <= OFS_W'(default_ofs); // [RQ22]
        full_ofs_q    <= OFS_W'(default_ofs);
      end
      else if (reg_wr && reg_addr_q == `DCFS_REG_EMPTY_OFS)
        empty_ofs_q <= hwdata_i[OFS_W-1:0];
      else if (reg_wr && reg_addr_q == `DCFS_REG_FULL_OFS)
        full_ofs_q <= hwdata_i[OFS_W-1:0];
    end
  end

  // pointers, fill level and output word
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      out_valid_q <= 1'b0;
      data_out_q  <= '0;
    end
    else if (ce_i)
    begin
      if (mrst)
      begin
        wr_ptr_q    <= '0; // [RQ23]
        rd_ptr_q    <= '0;
        count_q     <= '0;
        out_valid_q <= 1'b0;
        data_out_q  <= '0;
      end
      else
      begin
        if (wr_go)
          wr_ptr_q <= wr_ptr_q + ADDR_W'(1);
        if (mem_pop)
        begin
          rd_ptr_q   <= rd_ptr_q + ADDR_W'(1);
          data_out_q <= mem_q[rd_ptr_q];
        end
        count_q <= count_q + (ADDR_W+1)'(wr_go) - (ADDR_W+1)'(mem_pop);
        if (fall_1st)
          out_valid_q <= 1'b1; // [RQ2] [RQ14]
        else if (fall_rd && !mem_any)
          out_valid_q <= 1'b0; // [RQ21]
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && wr_go)
      mem_q[wr_ptr_q] <= din_s3_q; // [RQ4]
  end

  // flag synchronisers clocked by the pin clock edges
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      empty_sync_q <= '0;
      full_sync_q  <= '1;
      space_sync_q <= '0;
      fall_pipe_q  <= '0;
    end
    else if (ce_i)
    begin
      if (mrst)
      begin
        empty_sync_q <= '0; // [RQ23]
        full_sync_q  <= '1;
        space_sync_q <= '0;
        fall_pipe_q  <= '0;
      end
      else
      begin
        if (rclk_rise)
        begin
          empty_sync_q <= {empty_sync_q[0], mem_any}; // [RQ5] [RQ12] [RQ13]
          fall_pipe_q  <= {fall_pipe_q[0], mem_any}; // [RQ2] [RQ13]
        end
        if (wclk_rise)
        begin
          full_sync_q  <= {full_sync_q[0], ~full_raw}; // [RQ9] [RQ10] [RQ13]
          space_sync_q <= {space_sync_q[0], full_raw}; // [RQ18] [RQ19] [RQ13]
        end
      end
    end
  end

  // programmable and half flags follow the fill level directly
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      almost_empty_n_q <= 1'b0;
      half_full_n_q    <= 1'b1;
      almost_full_n_q  <= 1'b1;
    end
    else if (ce_i)
    begin
      almost_empty_n_q <= ~mrst & ae_n_d; // [RQ23]
      half_full_n_q    <= mrst | hf_n_d; // [RQ10] [RQ19]
      almost_full_n_q  <= mrst | af_n_d;
    end
  end

  // flags of the mode not in use are parked high
  assign data_out_o       = data_out_q;
  assign empty_flag_n_o   = fall | empty_sync_q[1];
  assign full_flag_n_o    = fall | full_sync_q[1];
  assign output_ready_n_o = ~fall | ~out_valid_q; // [RQ14] [RQ21]
  assign input_space_n_o  = ~fall | space_sync_q[1];
  assign almost_empty_n_o = almost_empty_n_q;
  assign half_full_n_o    = half_full_n_q;
  assign almost_full_n_o  = almost_full_n_q;

  // ahb-lite slave: one wait state, then an OKAY answer
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (reg_addr_q)
      `DCFS_REG_STATUS:
      begin
        rd_mux[`DCFS_ST_FALLTHROUGH]    = fall;
        rd_mux[`DCFS_ST_SERIAL_LOAD]    = serial_load_q;
        rd_mux[`DCFS_ST_EMPTY_N]        = empty_flag_n_o;
        rd_mux[`DCFS_ST_FULL_N]         = full_flag_n_o;
        rd_mux[`DCFS_ST_OUT_READY_N]    = output_ready_n_o;
        rd_mux[`DCFS_ST_INPUT_SPACE_N]  = input_space_n_o;
        rd_mux[`DCFS_ST_ALMOST_EMPTY_N] = almost_empty_n_q;
        rd_mux[`DCFS_ST_HALF_FULL_N]    = half_full_n_q;
        rd_mux[`DCFS_ST_ALMOST_FULL_N]  = almost_full_n_q;
      end
      `DCFS_REG_EMPTY_OFS:  rd_mux[OFS_W-1:0] = empty_ofs_q;
      `DCFS_REG_FULL_OFS:   rd_mux[OFS_W-1:0] = full_ofs_q;
      `DCFS_REG_WORD_COUNT: rd_mux[CW-1:0] = words;
      default:              rd_mux = '0;
    endcase
    if (!reg_hit_q)
      rd_mux = '0;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bus_q       <= dcfs_pkg::DCFS_BUS_IDLE;
      reg_addr_q  <= '0;
      reg_write_q <= 1'b0;
      reg_hit_q   <= 1'b0;
      hrdata_q    <= '0;
    end
    else if (ce_i)
    begin
      case (bus_q)
        dcfs_pkg::DCFS_BUS_WAIT:
        begin
          hrdata_q <= reg_write_q ? 32'h0000_0000 : rd_mux;
          bus_q    <= dcfs_pkg::DCFS_BUS_RESP;
        end
        dcfs_pkg::DCFS_BUS_IDLE,
        dcfs_pkg::DCFS_BUS_RESP:
          bus_q <= bus_take ? dcfs_pkg::DCFS_BUS_WAIT : dcfs_pkg::DCFS_BUS_IDLE;
        default:
          bus_q <= dcfs_pkg::DCFS_BUS_IDLE;
      endcase
      if (bus_take)
      begin
        reg_addr_q  <= haddr_i[7:0];
        reg_write_q <= hwrite_i;
        reg_hit_q   <= (haddr_i[31:4] == 28'h000_0000) && (haddr_i[1:0] == 2'h0)
                       && (hsize_i == 3'h2);
      end
    end
  end

  assign hreadyout_o = (bus_q != dcfs_pkg::DCFS_BUS_WAIT);
  assign hrdata_o    = hrdata_q;
  assign hresp_o     = 1'b0;

endmodule

`default_nettype wire

// *** tb/dcfs_fifo_props.sv ***
// concurrent checks on the fifo flag outputs and the bus handshake
`timescale 1ns/100ps
`default_nettype none
module dcfs_fifo_props (
  // clock, resets, mode strap
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       master_reset_n_i,
  input wire logic       fallthrough_select_serial_in_i,
  // flags
  input wire logic       empty_flag_n_o,
  input wire logic       full_flag_n_o,
  input wire logic       output_ready_n_o,
  input wire logic       input_space_n_o,
  input wire logic       almost_empty_n_o,
  input wire logic       half_full_n_o,
  input wire logic       almost_full_n_o,
  // bus handshake
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o
);
  logic mode_q;
  logic taken;
  logic run;
  // mode as seen during master reset; the parked, space, ready and empty checks wait until the pin is released
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mode_q <= 1'b0;
    else if (!master_reset_n_i)
      mode_q <= fallthrough_select_serial_in_i;
  end
  assign taken = hreadyout_o & hready_i & hsel_i & htrans_i[1];
  assign run = master_reset_n_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_std_parked;
    run && !mode_q |-> output_ready_n_o && input_space_n_o;
  endproperty
  a_std_parked: assert property (p_std_parked) else $error("ready flags active");
  property p_fall_parked;
    run && mode_q |-> empty_flag_n_o && full_flag_n_o;
  endproperty
  a_fall_parked: assert property (p_fall_parked) else $error("empty/full active");
  property p_not_both;
    empty_flag_n_o || full_flag_n_o;
  endproperty
  a_not_both: assert property (p_not_both) else $error("empty and full together");
  property p_full_half;
    !full_flag_n_o |-> !half_full_n_o;
  endproperty
  a_full_half: assert property (p_full_half) else $error("full without half");
  property p_full_fell;
    $fell(full_flag_n_o) |-> !almost_full_n_o;
  endproperty
  a_full_fell: assert property (p_full_fell) else $error("full before almost");
  property p_space_rose;
    run && mode_q && $rose(input_space_n_o) |-> !almost_full_n_o && !half_full_n_o;
  endproperty
  a_space_rose: assert property (p_space_rose) else $error("space closed early");
  property p_ready_rose;
    run && mode_q && $rose(output_ready_n_o) |-> !almost_empty_n_o;
  endproperty
  a_ready_rose: assert property (p_ready_rose) else $error("ready lost early");
  property p_empty_fell;
    run && $fell(empty_flag_n_o) |-> !almost_empty_n_o;
  endproperty
  a_empty_fell: assert property (p_empty_fell) else $error("empty early");
  property p_mreset;
    (!master_reset_n_i) [*8] |-> !almost_empty_n_o && half_full_n_o && almost_full_n_o;
  endproperty
  a_mreset: assert property (p_mreset) else $error("flags not cleared");
  property p_bus_wait;
    taken |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");
  property p_okay;
    hresp_o == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  c_full: cover property ($fell(full_flag_n_o));
  c_space: cover property ($rose(input_space_n_o));
  c_taken: cover property (taken ##2 hreadyout_o);
endmodule

bind dcfs_fifo dcfs_fifo_props props_u (
  .clk_i, .resetn_i, .master_reset_n_i, .fallthrough_select_serial_in_i,
  .empty_flag_n_o, .full_flag_n_o, .output_ready_n_o, .input_space_n_o,
  .almost_empty_n_o, .half_full_n_o, .almost_full_n_o,
  .hsel_i, .htrans_i, .hready_i, .hreadyout_o, .hresp_o
);
`default_nettype wire

// *** tb/dcfs_agents.sv ***
// writer and reader agents on their own free-running link clocks
`timescale 1ns/100ps
`default_nettype none
module dcfs_agents (
  // link clocks
  output logic        wclk_o,
  output logic        rclk_o,
  // write and read side
  output logic        wen_n_o,
  output logic        ren_n_o,
  output logic [35:0] data_o
);
  initial
  begin
    wclk_o = 1'b0;
    wen_n_o = 1'b1;
    ren_n_o = 1'b1;
    data_o = 36'h0;
    forever #32 wclk_o = ~wclk_o;
  end
  // read clock offset so the two never share an edge
  initial
  begin
    rclk_o = 1'b0;
    #11;
    forever #32 rclk_o = ~rclk_o;
  end
  // enable and data held across one whole rising edge, then data scrambled
  task automatic push(input logic [35:0] d);
    @(negedge wclk_o);
    wen_n_o <= 1'b0;
    data_o <= d;
    @(negedge wclk_o);
    wen_n_o <= 1'b1;
    data_o <= ~d;
  endtask
  // every word is requested in standard mode, the first one too; in fall-through mode the first word appears unasked
  task automatic pop();
    @(negedge rclk_o);
    ren_n_o <= 1'b0;
    @(negedge rclk_o);
    ren_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the dual-clock fifo in both timing modes
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int D = 16;
  localparam int N = 3;
  localparam int M = 2;
  logic        clk_i, resetn_i, mrst_n, mode, ld_n, sel0, sel1, fw;
  logic        wclk, rclk, wen_n, ren_n, hwrite, hrdy, hresp;
  logic [1:0]  htrans;
  wire logic [6:0] flags;
  logic [16:0] dflt [8];
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [35:0] din, dout;
  int          cap, n_errors, n_compared;

  dcfs_agents agents_u (
    .wclk_o(wclk), .rclk_o(rclk), .wen_n_o(wen_n), .ren_n_o(ren_n), .data_o(din)
  );
  // small depth keeps fill and drain short
  dcfs_fifo #(.DATA_W(36), .ADDR_W(4)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .wclk_i(wclk), .rclk_i(rclk),
    .write_enable_n_i(wen_n), .read_enable_n_i(ren_n), .master_reset_n_i(mrst_n),
    .fallthrough_select_serial_in_i(mode), .offset_load_n_i(ld_n),
    .offset_select0_i(sel0), .offset_select1_i(sel1), .data_in_i(din), .data_out_o(dout),
    .empty_flag_n_o(flags[6]), .full_flag_n_o(flags[5]), .output_ready_n_o(flags[4]),
    .input_space_n_o(flags[3]), .almost_empty_n_o(flags[2]), .half_full_n_o(flags[1]),
    .almost_full_n_o(flags[0]), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // {empty, full, out_ready, input_space, almost_empty, half, almost_full} for k words
  function automatic logic [6:0] ef(input logic f, input int k);
    if (f)
      return {1'b1, 1'b1, k == 0, k > D, k > N + 1, k <= D / 2 + 1, k < D + 1 - M};
    return {k > 0, k < D, 1'b1, 1'b1, k > N, k <= D / 2, k < D - M};
  endfunction

  function automatic logic [35:0] word(input int i);
    return {4'(i), 32'hC3A5_0000 + 32'(i)};
  endfunction

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    logic ok;
    @(posedge clk_i);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do
    begin
      @(negedge clk_i);
      ok = hrdy;
      @(posedge clk_i);
    end
    while (!ok);
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(negedge clk_i);
      ok = hrdy;
      r = hrdata;
      @(posedge clk_i);
    end
    while (!ok);
  endtask

  task automatic mrst(input logic f, input logic [2:0] p);
    @(posedge clk_i);
    mode <= f;
    {ld_n, sel1, sel0} <= p;
    mrst_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    mrst_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  // flags need two or three link edges to settle
  task automatic step(input int k);
    repeat (40) @(posedge clk_i);
    bus(1'b0, 32'h0C, 32'h0, rd);
    @(negedge clk_i);
    if (fw)
      check("flags", flags, ef(fw, k));
    else
      check("flags", flags, ef(fw, k));
    check("count", 36'(rd), 36'(k));
  endtask

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    close_out();
  end

  initial
  begin
    {resetn_i, mode, ld_n, sel0, sel1, hwrite, fw} = 7'h00;
    mrst_n = 1'b1;
    {haddr, hwdata, htrans} = 66'h0;
    {n_errors, n_compared} = 64'h0;
    dflt = '{17'h0007F, 17'h01FFF, 17'h03FFF, 17'h00FFF,
             17'h003FF, 17'h001FF, 17'h007FF, 17'h000FF};
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check("reset flags", flags, ef(1'b0, 0));
    // rows: strap pattern {load, select1, select0} against its default offset
    for (int r = 0; r < 8; r++)
    begin
      mrst(1'b0, r[2:0]);
      bus(1'b0, 32'h04, 32'h0, rd);
      check("empty offset", 36'(rd), 36'(dflt[r]));
      bus(1'b0, 32'h08, 32'h0, rd);
      check("full offset", 36'(rd), 36'(dflt[r]));
      bus(1'b0, 32'h00, 32'h0, rd);
      check("load mode", rd[1], r[2]);
    end
    // fill past capacity, then drain past empty, in each mode
    for (int f = 0; f < 2; f++)
    begin
      fw = f[0];
      cap = D + f;
      mrst(fw, 3'h0);
      bus(1'b1, 32'h04, 32'(N), rd);
      bus(1'b1, 32'h08, 32'(M), rd);
      bus(1'b0, 32'h00, 32'h0, rd);
      check("mode", rd[0], fw);
      for (int k = 1; k <= cap + 1; k++)
      begin
        agents_u.push(word(k - 1));
        step(k > cap ? cap : k);
        if (fw)
          check("first word", dout, word(0));
      end
      for (int k = cap; k >= 0; k--)
      begin
        if (fw && k > 0)
          check("head word", dout, word(cap - k));
        agents_u.pop();
        if (!fw && k > 0)
          check("read word", dout, word(cap - k));
        step(k > 0 ? k - 1 : 0);
      end
      if (!fw)
        check("read when empty", dout, word(cap - 1));
    end
    // mid-run reset with a word on the output: mode, pointers and flags start over
    agents_u.push(word(0));
    repeat (40) @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check("mid reset flags", flags, ef(1'b0, 0));
    check("mid reset word", dout, 36'h0);
    bus(1'b0, 32'h0C, 32'h0, rd);
    check("mid reset count", 36'(rd), 36'h0);
    bus(1'b1, 32'h10, 32'h5, rd);
    bus(1'b0, 32'h10, 32'h0, rd);
    check("unmapped", 36'(rd), 36'h0);
    close_out();
  end
endmodule
`default_nettype wire
